/* File: src/lfr_diag_regs.sv */
// Link diagnostic register bank: cable length and frequency offset
// Assumes an APB master on sys_clk and signal processor values
// that are synchronous to sys_clk
//
// Overview of operation
// - Low byte reports cable length in meters
// - Unknown cable length reads as all ones
// - Length meaningful only with 100 Mb/s link
// - Reserved bits ignore writes, read zero
// - Sample with select low fetches long-term offset
// - Sample with select high fetches control value
// - Sample request bit always reads zero
// - Result loaded only by sample, read-only
// - Result is signed byte, about 5.16 ppm/step
// - Result spans most negative to most positive
// - Control value is offset plus phase correction
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "lfr_consts.svh"
module lfr_diag_regs
  import lfr_pkg::*;
#(
  parameter int AW = 12,  // APB address width
  parameter int FW = 8    // Frequency result width
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic      [31:0]   prdata,
  output logic               pslverr,
  input  wire logic          link100Up,
  input  wire logic          lengthEstValid,
  input  wire logic [7:0]    lengthEstimate,
  input  wire logic [FW-1:0] dspFreqOffset,
  input  wire logic [FW-1:0] dspPhaseCorr,
  output logic               selectShortTerm,
  output logic      [FW-1:0] freqResult
);

  // ==========================================================
  // Elaboration checks
  generate
    if (AW < 10) begin : g_aw_chk
      $error("AW too small for the register indices");
    end
    if (FW != `LFR_FREQ_W) begin : g_fw_chk
      $error("FW must match the result field width");
    end
  endgenerate

  // ==========================================================
  // Declarations
  logic [`LFR_PAGE_W-1:0] pageSelect_q;    // Page select field
  logic                   sel_q;           // Short-term select bit
  logic                   sel_d;           // Next select bit
  logic [7:0]             lengthMeters;    // Cable length field
  logic [7:0]             lengthIn;        // Qualified length input
  logic                   lengthUnknown;   // Length not determinable
  logic [FW-1:0]          ctrlValue;       // Offset plus correction
  logic [FW-1:0]          fetchValue;      // Value picked by select
  logic                   sampleWr;        // Sample request write
  logic                   sampleSel;       // Select used by sample
  logic [AW-3:0]          wordIdx;         // Word index of address
  logic                   onDiagPage;      // Diagnostic page active
  lfr_reg_sel_t           regSel;          // Decoded register
  logic                   setupPh;         // APB setup cycle
  logic                   accessPh;        // APB access cycle
  logic                   wrAcc;           // Write taking effect
  logic                   err_q;           // Registered error answer
  logic                   err_d;           // Error for next access
  logic [31:0]            rdata_d;         // Read data for access

  // ==========================================================
  // APB phase decode
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrAcc    = accessPh & pwrite;
  assign wordIdx  = paddr[AW-1:`LFR_ADDR_LSB];
  assign onDiagPage = (pageSelect_q == `LFR_PAGE_DIAG);

  // Zero-wait slave: every access finishes in one cycle
  assign pready  = accessPh;
  assign pslverr = accessPh & err_q;

  // ==========================================================
  // Register decode
  // Diagnostic registers answer only on the diagnostic page
  always_comb begin
    regSel = LFR_SEL_NONE;
    if (paddr[`LFR_ADDR_LSB-1:0] != 2'h0) begin
      // Unaligned address maps to nothing
      regSel = LFR_SEL_NONE;
    end else if (wordIdx == (AW-2)'(`LFR_IDX_PAGE)) begin
      // Page select is always reachable
      regSel = LFR_SEL_PAGE;
    end else if (wordIdx == (AW-2)'(`LFR_IDX_LEN) && onDiagPage) begin
      regSel = LFR_SEL_LEN;
    end else if (wordIdx == (AW-2)'(`LFR_IDX_FREQ) && onDiagPage) begin
      regSel = LFR_SEL_FREQ;
    end
  end

  // ==========================================================
  // Page select register
  // Written through byte lane 0, other bits ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pageSelect_q <= `LFR_RST_PAGE;
    end else if (wrAcc && regSel == LFR_SEL_PAGE && pstrb[0]) begin
      pageSelect_q <= pwdata[`LFR_PAGE_W-1:0];
    end
  end

  // ==========================================================
  // Short-term select bit
  // The write that sets it also steers its own sample
  always_comb begin
    sel_d = sel_q;
    if (wrAcc && regSel == LFR_SEL_FREQ && pstrb[1]) begin
      sel_d = pwdata[`LFR_FREQ_SEL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= `LFR_RST_SEL;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign selectShortTerm = sel_q;

  // ==========================================================
  // Sample request
  // A one in the request bit is a strobe, never stored
  assign sampleWr  = wrAcc && regSel == LFR_SEL_FREQ && pstrb[1]
                     && pwdata[`LFR_FREQ_SMP_BIT];
  assign sampleSel = sel_d;

  // ==========================================================
  // Short-term control value
  // Clamped sum keeps the signed code inside its range
  lfr_sat_add #(
    .W   (FW)
  ) u_ctrl_sum (
    .a   (dspFreqOffset),
    .b   (dspPhaseCorr),
    .sum (ctrlValue)
  );

  // Pick long-term offset or control value
  assign fetchValue = sampleSel ? ctrlValue : dspFreqOffset;

  // ==========================================================
  // Frequency result
  // Loaded only by a sample, holds until the next one
  lfr_hold #(
    .W    (FW),
    .RST  (`LFR_RST_RES)
  ) u_result (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .load    (sampleWr),
    .din     (fetchValue),
    .dout    (freqResult)
  );

  // ==========================================================
  // Cable length
  // Unknown length, or no 100 Mb/s link, reads as all ones
  assign lengthUnknown = ~lengthEstValid | ~link100Up;
  assign lengthIn = lengthUnknown ? `LFR_LEN_UNKNOWN : lengthEstimate;

  // Refreshed every cycle from the estimator
  lfr_hold #(
    .W    (`LFR_LEN_W),
    .RST  (`LFR_RST_LEN)
  ) u_length (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .load    (1'b1),
    .din     (lengthIn),
    .dout    (lengthMeters)
  );

  // ==========================================================
  // Read data and error selection
  // Reserved bits and the request bit read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    case (regSel)
      LFR_SEL_PAGE: begin
        rdata_d[`LFR_PAGE_W-1:0] = pageSelect_q;
      end
      LFR_SEL_LEN: begin
        rdata_d[7:0] = lengthMeters;
      end
      LFR_SEL_FREQ: begin
        rdata_d[`LFR_FREQ_SEL_BIT] = sel_q;
        rdata_d[FW-1:0] = freqResult;
      end
      LFR_SEL_NONE: begin
        err_d = 1'b1;  // Unmapped or off-page
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Read data register
  // Taken at the setup edge so it stands through the access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // Error answer register, taken with the read data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else if (setupPh) begin
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Checks
  // The length register still holds its reset value at the release edge,
  // so the two attempts around that edge are skipped
  // Unknown length shows all ones one cycle later
  a_len_unknown: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) && lengthUnknown |=> lengthMeters == `LFR_LEN_UNKNOWN
  ) else $error("length not all ones when unknown");

  // Valid length copies the estimate
  a_len_copy: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) && !lengthUnknown |=> lengthMeters == $past(lengthEstimate)
  ) else $error("length does not follow estimate");

  // Length read keeps reserved bits zero
  // Read data was captured at the setup edge, one refresh earlier
  a_len_rsvd: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    setupPh && !pwrite && regSel == LFR_SEL_LEN
    |=> prdata[31:8] == 24'h000000 && prdata[7:0] == $past(lengthMeters)
  ) else $error("length read data wrong");

  // Frequency read never shows request or reserved bits
  a_freq_rsvd: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    setupPh && !pwrite && regSel == LFR_SEL_FREQ
    |=> prdata[31:9] == 23'h000000 && prdata[7:0] == freqResult
  ) else $error("frequency read shows reserved bits");

  // Request bit never shows in any read answer
  a_req_bit_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    accessPh && !pwrite |-> !prdata[`LFR_FREQ_SMP_BIT]
  ) else $error("request bit read back as one");

  // Long-term fetch
  a_long_fetch: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sampleWr && !sampleSel |=> freqResult == $past(dspFreqOffset)
  ) else $error("long-term offset not fetched");

  // Short-term fetch is offset plus correction, clamped
  a_short_fetch: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sampleWr && sampleSel |=> freqResult == $past(ctrlValue)
      && selectShortTerm
  ) else $error("control value not fetched");

  // Select bit follows a written one
  a_sel_set: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    wrAcc && regSel == LFR_SEL_FREQ && pstrb[1] && pwdata[`LFR_FREQ_SEL_BIT]
    |=> selectShortTerm
  ) else $error("select bit not set by write");

  // Select bit follows a written zero
  a_sel_clear: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    wrAcc && regSel == LFR_SEL_FREQ && pstrb[1] && !pwdata[`LFR_FREQ_SEL_BIT]
    |=> !selectShortTerm
  ) else $error("select bit not cleared by write");

  // Select bit holds between writes to its register
  a_sel_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !(wrAcc && regSel == LFR_SEL_FREQ && pstrb[1]) |=> $stable(selectShortTerm)
  ) else $error("select bit changed without write");

  // Result holds without a sample
  a_result_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !sampleWr |=> $stable(freqResult)
  ) else $error("result changed without sample");

  // Positive operands never give a negative control value
  a_sum_range: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !dspFreqOffset[FW-1] && !dspPhaseCorr[FW-1] |-> !ctrlValue[FW-1]
  ) else $error("control value wrapped");

  // Negative operands never give a positive control value
  a_neg_range: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    dspFreqOffset[FW-1] && dspPhaseCorr[FW-1] |-> ctrlValue[FW-1]
  ) else $error("control value wrapped upward");

  // Mixed signs cannot overflow, so the plain sum must come through
  a_sum_exact: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    dspFreqOffset[FW-1] != dspPhaseCorr[FW-1]
    |-> ctrlValue == FW'(dspFreqOffset + dspPhaseCorr)
  ) else $error("control value not offset plus correction");

  // Off-page diagnostic access is refused, and its write is ignored
  a_page_gate: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    setupPh && !onDiagPage && wordIdx == (AW-2)'(`LFR_IDX_FREQ)
    |=> pslverr ##1 $stable(freqResult)
  ) else $error("off-page access accepted");

  // Off-page length access is refused as well
  a_len_off_page: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    setupPh && !onDiagPage && wordIdx == (AW-2)'(`LFR_IDX_LEN)
    |=> pslverr
  ) else $error("off-page length access accepted");

endmodule

/* File: common/lfr_consts.svh */
// Constants for the link diagnostic length and frequency register bank
// Assumes inclusion by bare name from the package and the design files
`ifndef LFR_CONSTS_SVH
`define LFR_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define LFR_IDX_PAGE      8'h13
`define LFR_IDX_LEN       8'h14
`define LFR_IDX_FREQ      8'h15
`define LFR_ADDR_LSB      2

// ==========================================================
// Page select field
`define LFR_PAGE_W        2
`define LFR_PAGE_DIAG     2'h2
`define LFR_RST_PAGE      2'h0

// ==========================================================
// Cable length field
`define LFR_LEN_W         8
`define LFR_LEN_UNKNOWN   8'hFF
`define LFR_RST_LEN       8'h00

// ==========================================================
// Frequency offset indication fields
`define LFR_FREQ_SMP_BIT  15
`define LFR_FREQ_SEL_BIT  8
`define LFR_FREQ_W        8
`define LFR_RST_SEL       1'b0
`define LFR_RST_RES       8'h00

`endif

/* File: common/lfr_pkg.sv */
// Types shared by the diagnostic register bank files
// Assumes the constants header is on the include path
package lfr_pkg;
  `include "lfr_consts.svh"

  // ==========================================================
  // One-hot register decode
  typedef enum logic [3:0] {
    LFR_SEL_NONE = 4'h1,
    LFR_SEL_PAGE = 4'h2,
    LFR_SEL_LEN  = 4'h4,
    LFR_SEL_FREQ = 4'h8
  } lfr_reg_sel_t;
endpackage

/* File: src/lfr_hold.sv */
// Loadable holding register with a constant reset value
// Assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module lfr_hold #(
  parameter int          W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // ==========================================================
  // Storage
  // Captures din on load, keeps its value otherwise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dout <= RST;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule

/* File: src/lfr_sat_add.sv */
// Signed saturating adder for two's complement operands
// Assumes purely combinational use
`timescale 1ns/1ps
module lfr_sat_add #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic      [W-1:0] sum
);
  logic [W:0] wide;  // Sign-extended full sum

  // ==========================================================
  // Sum with clamping to the most positive or negative code
  always_comb begin
    wide = {a[W-1], a} + {b[W-1], b};
    if (wide[W] != wide[W-1]) begin
      // Overflow: clamp by sign of the true sum
      sum = wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end else begin
      sum = wide[W-1:0];
    end
  end
endmodule

/* File: verif/link_diag_length_freq_regs_bench.sv */
// Self-checking bench for the cable length and frequency offset register bank
// Assumes the constants header is on the include path and the package is compiled first
`timescale 1ns/1ps
`include "lfr_consts.svh"
module link_diag_length_freq_regs_bench
  import lfr_pkg::*;
;
  // ==========================================================
  // Stimulus and observation signals
  logic        sys_clk;          // 100 MHz clock
  logic        rstn;             // Active-low reset
  logic        psel;             // APB select
  logic        penable;          // APB access phase
  logic        pwrite;           // APB direction
  logic [11:0] paddr;            // APB byte address
  logic [31:0] pwdata;           // APB write data
  logic [3:0]  pstrb;            // APB byte strobes
  logic        pready;           // APB ready
  logic [31:0] prdata;           // APB read data
  logic        pslverr;          // APB error
  logic        link100Up;        // Fast link valid
  logic        lengthEstValid;   // Length estimator valid
  logic [7:0]  lengthEstimate;   // Length estimate in meters
  logic [7:0]  dspFreqOffset;    // Long-term offset
  logic [7:0]  dspPhaseCorr;     // Short-term phase correction
  logic        selectShortTerm;  // Select bit copy
  logic [7:0]  freqResult;       // Result field copy
  int          errCount;         // Mismatches seen
  int          numChecks;        // Comparisons made
  logic [31:0] rd;               // Last read data
  logic        er;               // Last error flag

  lfr_diag_regs i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .link100Up(link100Up), .lengthEstValid(lengthEstValid),
    .lengthEstimate(lengthEstimate), .dspFreqOffset(dspFreqOffset), .dspPhaseCorr(dspPhaseCorr),
    .selectShortTerm(selectShortTerm), .freqResult(freqResult)
  );

  // ==========================================================
  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Byte address of a register index
  function automatic logic [11:0] addrOf(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer: setup, then access until pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      errCount++;
      $display("BAD pready expected 1 seen %b", pready);
      final_report();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_reset_and_page();
    chk("freqResult", 32'h0, {24'h0, freqResult});
    chk("selectShortTerm", 32'h0, {31'h0, selectShortTerm});
    apb(1'b0, addrOf(`LFR_IDX_FREQ), 32'h0);
    chk("off page err", 32'h1, {31'h0, er});
    chk("off page data", 32'h0, rd);
    apb(1'b0, addrOf(`LFR_IDX_LEN), 32'h0);
    chk("off page len err", 32'h1, {31'h0, er});
    pstrb <= 4'hE;
    apb(1'b1, addrOf(`LFR_IDX_PAGE), 32'h2);
    pstrb <= 4'hF;
    apb(1'b0, addrOf(`LFR_IDX_PAGE), 32'h0);
    chk("page lane off", 32'h0, rd);
    apb(1'b1, addrOf(`LFR_IDX_PAGE), 32'h2);
    apb(1'b0, addrOf(`LFR_IDX_FREQ), 32'h0);
    chk("on page err", 32'h0, {31'h0, er});
    chk("freq reset", 32'h0, rd);
    apb(1'b0, 12'h058, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, addrOf(`LFR_IDX_FREQ) + 12'h001, 32'h0);
    chk("unaligned err", 32'h1, {31'h0, er});
  endtask

  task automatic sc_length(input logic up, input logic vld, input logic [7:0] est, input logic [7:0] exp);
    link100Up      <= up;
    lengthEstValid <= vld;
    lengthEstimate <= est;
    apb(1'b1, addrOf(`LFR_IDX_LEN), 32'hFFFF_FFFF);
    apb(1'b0, addrOf(`LFR_IDX_LEN), 32'h0);
    chk("length", {24'h0, exp}, rd);
  endtask

  task automatic sc_sample(input logic [31:0] wd, input logic [7:0] off, input logic [7:0] ph,
                           input logic [31:0] exp);
    dspFreqOffset <= off;
    dspPhaseCorr  <= ph;
    apb(1'b1, addrOf(`LFR_IDX_FREQ), wd);
    apb(1'b0, addrOf(`LFR_IDX_FREQ), 32'h0);
    chk("freq read", exp, rd);
    chk("freqResult port", {24'h0, exp[7:0]}, {24'h0, freqResult});
    chk("selectShortTerm", {31'h0, exp[8]}, {31'h0, selectShortTerm});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    errCount = 0;
    numChecks = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    link100Up = 1'b0;
    lengthEstValid = 1'b0;
    lengthEstimate = 8'h00;
    dspFreqOffset = 8'h00;
    dspPhaseCorr = 8'h00;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    sc_reset_and_page();
    sc_length(1'b1, 1'b1, 8'h2A, 8'h2A);
    sc_length(1'b1, 1'b0, 8'h2A, `LFR_LEN_UNKNOWN);
    sc_length(1'b0, 1'b1, 8'h33, `LFR_LEN_UNKNOWN);
    sc_length(1'b1, 1'b1, 8'hFE, 8'hFE);
    sc_sample(32'h0000_8000, 8'h80, 8'h05, 32'h0000_0080);
    sc_sample(32'h0000_8100, 8'h7F, 8'h05, 32'h0000_017F);
    sc_sample(32'h0000_8100, 8'h10, 8'hF0, 32'h0000_0100);
    sc_sample(32'h0000_7EFF, 8'h22, 8'h01, 32'h0000_0000);
    sc_sample(32'h0000_8000, 8'h7F, 8'h05, 32'h0000_007F);
    sc_sample(32'h0000_0100, 8'h90, 8'h90, 32'h0000_017F);
    sc_sample(32'h0000_8100, 8'h90, 8'h90, 32'h0000_0180);
    apb(1'b0, addrOf(`LFR_IDX_PAGE), 32'h0);
    chk("page read", 32'h2, rd);
    final_report();
  end
endmodule
